// File: core/tio_regs.svh
// Constants for the timed I/O port: counts, widths and reset values
`ifndef TIO_REGS_SVH
`define TIO_REGS_SVH

// ********
// Clock blocks
// ********
`define TIO_CB_COUNT      6
`define TIO_CB_REF        3'h0
`define TIO_CB_SEL_W      3
`define TIO_DIV_W         8
`define TIO_DIV_RST       8'h00
`define TIO_REF_MHZ       100

// ********
// Port datapath
// ********
`define TIO_PORT_W_DEF    8
`define TIO_XFER_W        32
`define TIO_CNT_W         16
`define TIO_CNT_RST       16'h0000
`define TIO_CNT_STEP      16'h0001
`define TIO_FIFO_DEPTH    32
`define TIO_XFER_RST      32'h0000_0000

`endif

// File: core/tio_pkg.sv
// Types shared by the timed I/O port and its buffer
package tio_pkg;
`include "tio_regs.svh"

    // ********
    // Conditions for a waiting input
    // ********
    typedef enum logic [1:0] {
        TIO_COND_NONE,
        TIO_COND_EQ,
        TIO_COND_NEQ
    } tio_cond_type;

    // ********
    // Carriers
    // ********
    typedef struct packed {
        logic [`TIO_XFER_W-1:0] data;
        logic                   timed;
        logic [`TIO_CNT_W-1:0]  at_time;
    } tio_out_cmd_type;

    typedef struct packed {
        tio_cond_type           cond;
        logic [`TIO_XFER_W-1:0] cond_val;
        logic                   timed;
        logic [`TIO_CNT_W-1:0]  at_time;
    } tio_in_cmd_type;

    typedef struct packed {
        logic [`TIO_XFER_W-1:0] data;
        logic [`TIO_CNT_W-1:0]  stamp;
    } tio_in_data_type;

    typedef struct packed {
        logic                  src_pin;
        logic [`TIO_DIV_W-1:0] div;
    } tio_cb_cfg_type;

endpackage

// File: core/tio_fifo.sv
// Synchronous FIFO with valid/ready on both sides
module tio_fifo
    import tio_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = `TIO_FIFO_DEPTH
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);

    generate
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
            $error("tio_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + AW'(1);
            end
            if (pop) begin
                rd_q <= rd_q + AW'(1);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + (AW+1)'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - (AW+1)'(1);
            end
        end
    end
endmodule // tio_fifo

// File: core/tio_port.sv
// Timed I/O port with clock blocks, serializer, counter and pin sharing
//
// Functional notes
// R1 - Port width is 1, 4, 8, 16 or 32 pins, fixed per instance.
// R2 - All pins of the port share one direction, in or out.
// R3 - Port drives pins or samples them, optionally waiting for a pin condition.
// R4 - Open-drain: zero pulls low, one leaves the pin undriven.
// R5 - Data passes through a FIFO, transfer register and serializer. Only output data has a FIFO; input data goes through the deserializer alone.
// R6 - A 16-bit port counter decides when data moves to or from pins.
// R7 - Counter readable any time; transfers may wait for a counter value.
// R8 - Each transfer captures the counter value as a readable timestamp.
// R9 - An enabled link sharing the pins disables the port's pins.
// R10 - Narrower enabled ports claim shared pins; unshared pins stay usable.
// R11 - The port always transfers at its full width despite sharing.
// R12 - Six clock blocks; block 0 is the reference clock, others programmable.
// R13 - A clock block may use a 1-bit pin input, optionally divided.
// R14 - Input strobe qualifies sampled data; output strobe marks driven data.
// R15 - After reset the port is attached to clock block 0.
// R16 - Pin conditions are signalled as events, not interrupts.
// R17 - Each core access to the port is taken in one cycle; pushes wait on a full FIFO, input requests until the input path is idle.
// R18 - Counter steps once per governing clock tick, wrapping at 2^16.
module tio_port
    import tio_pkg::*;
#(
    parameter int PORT_W = `TIO_PORT_W_DEF,
    parameter int DEPTH  = `TIO_FIFO_DEPTH
) (
    input  wire logic                                REF_CLK_I,
    input  wire logic                                SYS_RST_I,
    input  wire tio_cb_cfg_type [`TIO_CB_COUNT-1:1]  CB_CFG_I,
    input  wire logic           [`TIO_CB_COUNT-1:1]  CB_SRC_PIN_I,
    input  wire logic                                CB_SEL_LOAD_I,
    input  wire logic           [`TIO_CB_SEL_W-1:0]  CB_SEL_I,
    input  wire logic                                DIR_OUT_I,
    input  wire logic                                OPEN_DRAIN_I,
    input  wire logic                                SER_EN_I,
    input  wire logic                                STB_IN_EN_I,
    input  wire logic                                STB_OUT_EN_I,
    input  wire logic                                LINK_EN_I,
    input  wire logic           [PORT_W-1:0]         NARROW_CLAIM_I,
    input  wire logic                                OUT_VALID_I,
    output logic                                     OUT_READY_O,
    input  wire tio_out_cmd_type                     OUT_CMD_I,
    input  wire logic                                IN_REQ_VALID_I,
    output logic                                     IN_REQ_READY_O,
    input  wire tio_in_cmd_type                      IN_REQ_I,
    output logic                                     IN_VALID_O,
    input  wire logic                                IN_READY_I,
    output tio_in_data_type                          IN_DATA_O,
    output logic                [`TIO_CNT_W-1:0]     COUNTER_O,
    output logic                [`TIO_CNT_W-1:0]     OUT_STAMP_O,
    output logic                                     EVENT_O,
    input  wire logic           [PORT_W-1:0]         PIN_I,
    output logic                [PORT_W-1:0]         PIN_O,
    output logic                [PORT_W-1:0]         PIN_OE_O,
    input  wire logic                                INPUT_STROBE_I,
    output logic                                     OUTPUT_STROBE_O
);
    localparam int NCB    = `TIO_CB_COUNT;
    localparam int XW     = `TIO_XFER_W;
    localparam int CW     = `TIO_CNT_W;
    localparam int SHIFTS = XW / PORT_W;
    localparam int RW     = $clog2(SHIFTS + 1);
    localparam int IW     = (SHIFTS > 1) ? $clog2(SHIFTS) : 1;

    // ********
    // Elaboration checks
    // ********
    generate
        if (PORT_W != 1 && PORT_W != 4 && PORT_W != 8 && PORT_W != 16 && PORT_W != 32)
        begin : g_bad_w
            $error("tio_port: PORT_W must be 1, 4, 8, 16 or 32"); // R1
        end
    endgenerate

    // ********
    // Helpers
    // ********
    function automatic logic time_ok(input logic timed, input logic [CW-1:0] at_time,
                                     input logic [CW-1:0] cnt);
        time_ok = !timed || (at_time == cnt);
    endfunction

    function automatic logic cond_met(input tio_cond_type cond, input logic [PORT_W-1:0] pins,
                                      input logic [XW-1:0] val);
        cond_met = 1'b1;
        unique case (cond)
            TIO_COND_NONE: cond_met = 1'b1;
            TIO_COND_EQ:   cond_met = (pins == val[PORT_W-1:0]);
            TIO_COND_NEQ:  cond_met = (pins != val[PORT_W-1:0]);
            default:       cond_met = 1'b1;
        endcase
    endfunction

    // ********
    // Clock blocks
    // ********
    wire logic [NCB-1:0] cb_tick;

    assign cb_tick[0] = 1'b1; // R12

    genvar gi;
    generate
        for (gi = 1; gi < NCB; gi++) begin : g_cb
            logic                  s1_q;
            logic                  s2_q;
            logic                  s3_q;
            logic [`TIO_DIV_W-1:0] div_q;
            logic                  src_ev;

            always_ff @(posedge REF_CLK_I) begin
                if (SYS_RST_I) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                end else begin
                    s1_q <= CB_SRC_PIN_I[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                end
            end

            assign src_ev = CB_CFG_I[gi].src_pin ? (s2_q && !s3_q) : 1'b1; // R13

            always_ff @(posedge REF_CLK_I) begin
                if (SYS_RST_I) begin
                    div_q <= `TIO_DIV_RST;
                end else if (src_ev) begin
                    if (div_q >= CB_CFG_I[gi].div) begin
                        div_q <= `TIO_DIV_RST;
                    end else begin
                        div_q <= div_q + `TIO_DIV_W'(1); // R12
                    end
                end
            end

            assign cb_tick[gi] = src_ev && (div_q >= CB_CFG_I[gi].div); // R13
        end
    endgenerate

    logic [`TIO_CB_SEL_W-1:0] cb_sel_q;
    logic                     port_tick;

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            cb_sel_q <= `TIO_CB_REF; // R15
        end else if (CB_SEL_LOAD_I && (CB_SEL_I < `TIO_CB_SEL_W'(NCB))) begin
            cb_sel_q <= CB_SEL_I;
        end
    end

    assign port_tick = cb_tick[cb_sel_q];

    // ********
    // Pin synchronisers and port counter
    // ********
    logic [PORT_W-1:0] pin_s1_q;
    logic [PORT_W-1:0] pin_s2_q;
    logic              stb_s1_q;
    logic              stb_s2_q;
    logic [CW-1:0]     counter_q;

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            stb_s1_q <= 1'b0;
            stb_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= PIN_I;
            pin_s2_q <= pin_s1_q;
            stb_s1_q <= INPUT_STROBE_I;
            stb_s2_q <= stb_s1_q;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            counter_q <= `TIO_CNT_RST;
        end else if (port_tick) begin
            counter_q <= counter_q + `TIO_CNT_STEP; // R6 R18
        end
    end

    assign COUNTER_O = counter_q; // R7

    // ********
    // Output path: FIFO, transfer register, serializer
    // ********
    typedef enum logic {OUT_IDLE, OUT_SHIFT} tio_out_state_type;

    tio_out_state_type out_state_q;
    tio_out_cmd_type   fifo_cmd;
    logic              fifo_valid;
    logic              fifo_pop;
    logic [XW-1:0]     xfer_q;
    logic [RW-1:0]     remain_q;
    logic [PORT_W-1:0] drive_q;
    logic              ostb_q;
    logic [CW-1:0]     ostamp_q;
    logic [PORT_W-1:0] own;

    tio_fifo #(
        .WIDTH ($bits(tio_out_cmd_type)),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk_i       (REF_CLK_I),
        .rst_i       (SYS_RST_I),
        .in_valid_i  (OUT_VALID_I),
        .in_ready_o  (OUT_READY_O),
        .in_data_i   (OUT_CMD_I),
        .out_valid_o (fifo_valid),
        .out_ready_i (fifo_pop),
        .out_data_o  (fifo_cmd)
    ); // R5 R17

    assign fifo_pop = DIR_OUT_I && port_tick && (out_state_q == OUT_IDLE) && fifo_valid
                      && time_ok(fifo_cmd.timed, fifo_cmd.at_time, counter_q); // R7

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            out_state_q <= OUT_IDLE;
            xfer_q      <= `TIO_XFER_RST;
            remain_q    <= '0;
            drive_q     <= '0;
            ostb_q      <= 1'b0;
            ostamp_q    <= `TIO_CNT_RST;
        end else if (port_tick) begin
            unique case (out_state_q)
                OUT_IDLE: begin
                    ostb_q <= fifo_pop; // R14
                    if (fifo_pop) begin
                        drive_q  <= fifo_cmd.data[PORT_W-1:0];
                        xfer_q   <= fifo_cmd.data >> PORT_W; // R5
                        ostamp_q <= counter_q; // R8
                        if (SER_EN_I && SHIFTS > 1) begin
                            remain_q    <= RW'(SHIFTS - 1);
                            out_state_q <= OUT_SHIFT;
                        end
                    end
                end
                OUT_SHIFT: begin
                    ostb_q   <= 1'b1; // R14
                    drive_q  <= xfer_q[PORT_W-1:0]; // R11
                    xfer_q   <= xfer_q >> PORT_W;
                    remain_q <= remain_q - RW'(1);
                    if (remain_q == RW'(1)) begin
                        out_state_q <= OUT_IDLE;
                    end
                end
            endcase
        end
    end

    assign OUT_STAMP_O = ostamp_q; // R8

    // ********
    // Pin drivers and sharing
    // ********
    assign own = LINK_EN_I ? '0 : ~NARROW_CLAIM_I; // R9 R10

    assign PIN_O    = OPEN_DRAIN_I ? '0 : drive_q; // R4
    assign PIN_OE_O = !DIR_OUT_I ? '0 :
                      (OPEN_DRAIN_I ? (own & ~drive_q) : own); // R2 R3 R4

    assign OUTPUT_STROBE_O = STB_OUT_EN_I && DIR_OUT_I && ostb_q; // R14

    // ********
    // Input path: conditional wait, deserializer, timestamp
    // ********
    typedef enum logic [1:0] {IN_IDLE, IN_WAIT, IN_SHIFT, IN_HOLD} tio_in_state_type;

    tio_in_state_type in_state_q;
    tio_in_cmd_type   req_q;
    logic [XW-1:0]    sh_q;
    logic [IW-1:0]    idx_q;
    logic [CW-1:0]    istamp_q;
    logic             event_q;
    logic             sample_ok;
    logic             start_ok;

    assign IN_REQ_READY_O = !DIR_OUT_I && (in_state_q == IN_IDLE); // R17
    assign IN_VALID_O     = (in_state_q == IN_HOLD);
    assign sample_ok      = port_tick && (!STB_IN_EN_I || stb_s2_q); // R14
    assign start_ok       = sample_ok && time_ok(req_q.timed, req_q.at_time, counter_q)
                            && cond_met(req_q.cond, pin_s2_q, req_q.cond_val); // R3 R7

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            in_state_q <= IN_IDLE;
            req_q      <= '0;
            sh_q       <= `TIO_XFER_RST;
            idx_q      <= '0;
            istamp_q   <= `TIO_CNT_RST;
            event_q    <= 1'b0;
        end else begin
            event_q <= 1'b0;
            unique case (in_state_q)
                IN_IDLE: begin
                    if (IN_REQ_VALID_I && IN_REQ_READY_O) begin
                        req_q      <= IN_REQ_I;
                        sh_q       <= `TIO_XFER_RST;
                        in_state_q <= IN_WAIT;
                    end
                end
                IN_WAIT: begin
                    if (start_ok) begin
                        sh_q[PORT_W-1:0] <= pin_s2_q; // R11
                        istamp_q         <= counter_q; // R8
                        idx_q            <= IW'(1);
                        if (SER_EN_I && SHIFTS > 1) begin
                            in_state_q <= IN_SHIFT;
                        end else begin
                            in_state_q <= IN_HOLD;
                            event_q    <= 1'b1; // R16
                        end
                    end
                end
                IN_SHIFT: begin
                    if (sample_ok) begin
                        sh_q[idx_q*PORT_W +: PORT_W] <= pin_s2_q; // R5
                        idx_q                        <= idx_q + IW'(1);
                        if (idx_q == IW'(SHIFTS - 1)) begin
                            in_state_q <= IN_HOLD;
                            event_q    <= 1'b1; // R16
                        end
                    end
                end
                IN_HOLD: begin
                    if (IN_READY_I) begin
                        in_state_q <= IN_IDLE;
                    end
                end
            endcase
        end
    end

    assign IN_DATA_O.data  = sh_q;
    assign IN_DATA_O.stamp = istamp_q;
    assign EVENT_O         = event_q; // R16
endmodule // tio_port

// File: verif/tio_port_sva.sv
// Concurrent checks on the timed I/O port's top-level ports
module tio_port_sva
    import tio_pkg::*;
#(
    parameter int PORT_W = 8
) (
    input wire logic                       REF_CLK_I,
    input wire logic                       SYS_RST_I,
    input wire logic                       CB_SEL_LOAD_I,
    input wire logic [`TIO_CB_SEL_W-1:0]   CB_SEL_I,
    input wire logic                       DIR_OUT_I,
    input wire logic                       OPEN_DRAIN_I,
    input wire logic                       SER_EN_I,
    input wire logic                       STB_OUT_EN_I,
    input wire logic                       LINK_EN_I,
    input wire logic [PORT_W-1:0]          NARROW_CLAIM_I,
    input wire logic                       IN_REQ_READY_O,
    input wire logic                       IN_VALID_O,
    input wire logic                       IN_READY_I,
    input wire tio_in_data_type            IN_DATA_O,
    input wire logic [`TIO_CNT_W-1:0]      COUNTER_O,
    input wire logic [`TIO_CNT_W-1:0]      OUT_STAMP_O,
    input wire logic                       EVENT_O,
    input wire logic [PORT_W-1:0]          PIN_O,
    input wire logic [PORT_W-1:0]          PIN_OE_O,
    input wire logic                       OUTPUT_STROBE_O
);
    // ********************************
    // Selected clock block shadow
    // ********************************
    logic [`TIO_CB_SEL_W-1:0] sel_q;

    always_ff @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            sel_q <= `TIO_CB_REF;
        end else if (CB_SEL_LOAD_I && CB_SEL_I < 3'h6) begin
            sel_q <= CB_SEL_I;
        end
    end

    default clocking dc @(posedge REF_CLK_I);
    endclocking
    default disable iff (SYS_RST_I);

    chk_link_release: assert property (LINK_EN_I && $past(LINK_EN_I) |-> PIN_OE_O == '0)
        else $error("pin driven while link enabled");
    chk_claim_yield: assert property ($stable(NARROW_CLAIM_I) |-> (PIN_OE_O & NARROW_CLAIM_I) == '0)
        else $error("claimed pin still driven");
    chk_input_quiet: assert property (!DIR_OUT_I && !$past(DIR_OUT_I) |-> PIN_OE_O == '0)
        else $error("input port drives a pin");
    chk_drain_low: assert property (OPEN_DRAIN_I && $past(OPEN_DRAIN_I) |-> PIN_O == '0)
        else $error("open drain pin driven high");
    chk_count_step: assert property (sel_q == 3'h0 && $past(sel_q) == 3'h0 && $past(sel_q, 2) == 3'h0
        && !$past(SYS_RST_I) |-> COUNTER_O == $past(COUNTER_O) + 16'h0001)
        else $error("counter missed a reference tick");
    chk_event_rise: assert property (1'b1 |-> EVENT_O == $rose(IN_VALID_O))
        else $error("event pulse not tied to valid rise");
    chk_in_hold: assert property (IN_VALID_O && !IN_READY_I |=> IN_VALID_O && $stable(IN_DATA_O))
        else $error("input data dropped before taken");
    chk_out_stamp: assert property (OUTPUT_STROBE_O && !SER_EN_I && sel_q == 3'h0
        |-> OUT_STAMP_O == $past(COUNTER_O))
        else $error("output stamp not load time");
    chk_strobe_gate: assert property (!(STB_OUT_EN_I && DIR_OUT_I) |-> !OUTPUT_STROBE_O)
        else $error("output strobe while disabled");
    chk_dir_refuse: assert property (DIR_OUT_I |-> !IN_REQ_READY_O)
        else $error("input request taken on output port");
endmodule // tio_port_sva

bind tio_port tio_port_sva #(.PORT_W(PORT_W)) u_sva (
    .REF_CLK_I, .SYS_RST_I, .CB_SEL_LOAD_I, .CB_SEL_I, .DIR_OUT_I, .OPEN_DRAIN_I, .SER_EN_I,
    .STB_OUT_EN_I, .LINK_EN_I, .NARROW_CLAIM_I, .IN_REQ_READY_O, .IN_VALID_O, .IN_READY_I,
    .IN_DATA_O, .COUNTER_O, .OUT_STAMP_O, .EVENT_O, .PIN_O, .PIN_OE_O, .OUTPUT_STROBE_O
);

// File: verif/tio_ext_hw.sv
// Application hardware on the far side of the port pins
module tio_ext_hw
    import tio_pkg::*;
#(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic [W-1:0] pin_o_i,
    input  wire logic [W-1:0] pin_oe_i,
    input  wire logic [W-1:0] ext_val_i,
    input  wire logic         ext_en_i,
    input  wire logic         ostb_i,
    output logic      [W-1:0] pin_i_o,
    output logic      [5:1]   src_o,
    output logic      [W-1:0] seen_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // ********************************
    // Pin level, pull-down when idle
    // ********************************
    always_comb pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & (ext_en_i ? ext_val_i : '0));

    initial begin
        src_o = '0;
        seen_o = '0;
    end

    always @(posedge clk_i) if (ostb_i) seen_o <= pin_i_o;

    // Source clock stands still between bursts
    task automatic src_pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk_i);
            #1 src_o[1] = 1'b1;
            repeat (4) @(posedge clk_i);
            #1 src_o[1] = 1'b0;
        end
    endtask
endmodule // tio_ext_hw

// File: verif/tio_port_tb_top.sv
// Self-checking testbench for the timed I/O port
module tio_port_tb_top
    import tio_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic                 clk = 1'b0;
    logic                 rst = 1'b1;
    tio_cb_cfg_type [5:1] cb_cfg;
    logic [5:1]           src;
    logic [2:0]           cb_sel;
    logic                 cb_ld, dir, od, ser, sie, soe, link, ovld, ordy, rq_vld, rq_rdy;
    logic                 ivld, irdy, ev, istb, ostb, ext_en;
    logic [7:0]           claim, pin_i, pin_o, pin_oe, ext_val, seen;
    tio_out_cmd_type      ocmd;
    tio_in_cmd_type       rq;
    tio_in_data_type      idat;
    logic [15:0]          cnt, ostamp;
    int                   errors, n_compared;

    always #5 clk = ~clk;

    tio_port #(.PORT_W(8), .DEPTH(32)) DUT (
        .REF_CLK_I(clk), .SYS_RST_I(rst), .CB_CFG_I(cb_cfg), .CB_SRC_PIN_I(src),
        .CB_SEL_LOAD_I(cb_ld), .CB_SEL_I(cb_sel), .DIR_OUT_I(dir), .OPEN_DRAIN_I(od),
        .SER_EN_I(ser), .STB_IN_EN_I(sie), .STB_OUT_EN_I(soe), .LINK_EN_I(link),
        .NARROW_CLAIM_I(claim), .OUT_VALID_I(ovld), .OUT_READY_O(ordy), .OUT_CMD_I(ocmd),
        .IN_REQ_VALID_I(rq_vld), .IN_REQ_READY_O(rq_rdy), .IN_REQ_I(rq), .IN_VALID_O(ivld),
        .IN_READY_I(irdy), .IN_DATA_O(idat), .COUNTER_O(cnt), .OUT_STAMP_O(ostamp),
        .EVENT_O(ev), .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(pin_oe),
        .INPUT_STROBE_I(istb), .OUTPUT_STROBE_O(ostb)
    );

    tio_ext_hw #(.W(8)) u_ext (
        .clk_i(clk), .pin_o_i(pin_o), .pin_oe_i(pin_oe), .ext_val_i(ext_val),
        .ext_en_i(ext_en), .ostb_i(ostb), .pin_i_o(pin_i), .src_o(src), .seen_o(seen)
    );

    // ********
    // Shared tasks
    // ********
    task automatic step(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wrap_up;
        $display("errors %0d compared %0d", errors, n_compared);
        if (errors == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wait_for(input int w);
        logic [3:0] s;
        for (int i = 0; i <= 300; i++) begin
            s = {rq_rdy, ordy, ivld, ostb};
            if (s[w] === 1'b1) return;
            step();
        end
        errors++;
        wrap_up();
    endtask

    task automatic push(input logic [31:0] d, input logic tm, input logic [15:0] at);
        ocmd = '{d, tm, at};
        ovld = 1'b1;
        wait_for(2);
        step();
        ovld = 1'b0;
    endtask

    task automatic req(input tio_cond_type c, input logic [31:0] v, input logic tm,
                       input logic [15:0] at);
        rq = '{c, v, tm, at};
        rq_vld = 1'b1;
        wait_for(3);
        step();
        rq_vld = 1'b0;
    endtask

    task automatic take(input logic [7:0] exp);
        wait_for(1'b1);
        chk(ev, 1'b1);
        chk(idat.data[7:0], exp);
        irdy = 1'b1;
        step();
        irdy = 1'b0;
    endtask

    // ********
    // Scenarios
    // ********
    task automatic t_reset;
        logic [15:0] c;
        chk(pin_oe, 8'h00);
        chk({ivld, ev, ordy}, 3'h1);
        c = cnt;
        step(5);
        chk(cnt, c + 16'h0005);
    endtask

    task automatic t_out;
        dir = 1'b1;
        soe = 1'b1;
        step();
        push(32'h0000_00A5, 1'b0, 16'h0000);
        wait_for(1'b0);
        chk(pin_o, 8'hA5);
        chk(pin_oe, 8'hFF);
        chk(ostamp, cnt - 16'h0001);
        step();
        chk(seen, 8'hA5);
        ser = 1'b1;
        push(32'h4433_2211, 1'b0, 16'h0000);
        wait_for(1'b0);
        for (int k = 0; k < 4; k++) begin
            chk(pin_o, 8'h11 * (k + 1));
            step();
        end
        ser = 1'b0;
    endtask

    task automatic t_timed;
        logic [15:0] at;
        at = cnt + 16'h0014;
        push(32'h0000_003C, 1'b1, at);
        wait_for(1'b0);
        chk(ostamp, at);
    endtask

    task automatic t_fifo;
        int n;
        push(32'h0000_0000, 1'b1, cnt + 16'h0064);
        step();
        n = 1;
        ovld = 1'b1;
        for (int i = 1; i < 40; i++) begin
            ocmd = '{i, 1'b0, 16'h0000};
            if (ordy !== 1'b1) break;
            n++;
            step();
        end
        ovld = 1'b0;
        chk(n, 32);
        n = 0;
        for (int i = 0; i < 300; i++) begin
            if (ostb === 1'b1) n++;
            step();
        end
        chk(n, 32);
        chk(pin_o, 8'h1F);
    endtask

    task automatic t_pins;
        od = 1'b1;
        push(32'h0000_000F, 1'b0, 16'h0000);
        wait_for(1'b0);
        chk(pin_o, 8'h00);
        chk(pin_oe, 8'hF0);
        od = 1'b0;
        push(32'h0000_00FF, 1'b0, 16'h0000);
        wait_for(1'b0);
        link = 1'b1;
        step(2);
        chk(pin_oe, 8'h00);
        link = 1'b0;
        claim = 8'h0F;
        step(2);
        chk(pin_oe, 8'hF0);
        claim = 8'h00;
        step(2);
        chk(pin_oe, 8'hFF);
    endtask

    task automatic t_input;
        logic [15:0] at;
        dir = 1'b0;
        ext_en = 1'b1;
        ext_val = 8'h5A;
        step(3);
        at = cnt + 16'h001E;
        req(TIO_COND_EQ, 32'h0000_005A, 1'b1, at);
        wait_for(1'b1);
        chk(idat.stamp, at);
        take(8'h5A);
        req(TIO_COND_NEQ, 32'h0000_005A, 1'b0, 16'h0000);
        step(12);
        chk(ivld, 1'b0);
        ext_val = 8'h3C;
        take(8'h3C);
        sie = 1'b1;
        step(3);
        req(TIO_COND_NONE, 32'h0000_0000, 1'b0, 16'h0000);
        step(12);
        chk(ivld, 1'b0);
        istb = 1'b1;
        take(8'h3C);
        sie = 1'b0;
        istb = 1'b0;
    endtask

    task automatic t_clk;
        logic [15:0] c;
        cb_cfg[1] = {1'b1, 8'h01};
        cb_sel = 3'h1;
        cb_ld = 1'b1;
        step();
        cb_ld = 1'b0;
        step(4);
        c = cnt;
        step(4);
        chk(cnt, c);
        u_ext.src_pulses(6);
        step(8);
        chk(cnt, c + 16'h0003);
        cb_sel = 3'h6;
        cb_ld = 1'b1;
        step();
        cb_ld = 1'b0;
        step(8);
        chk(cnt, c + 16'h0003);
        cb_cfg[2] = {1'b0, 8'h03};
        cb_sel = 3'h2;
        cb_ld = 1'b1;
        step();
        cb_ld = 1'b0;
        step(8);
        c = cnt;
        step(40);
        chk(cnt, c + 16'h000A);
    endtask

    initial begin
        errors = 0;
        n_compared = 0;
        {cb_cfg, cb_sel, cb_ld, dir, od, ser, sie, soe, link, claim} = '0;
        {ovld, ocmd, rq_vld, rq, irdy, istb, ext_en, ext_val} = '0;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        step();
        t_reset();
        t_out();
        t_timed();
        t_fifo();
        t_pins();
        t_input();
        t_clk();
        wrap_up();
    end
endmodule // tio_port_tb_top
